// File: rtl/sca_pkg.sv
package sca_pkg;

  // ============================================================
  // SPI command and strap encodings
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [1:0] STRAP_SPI = 2'h2;

  // ============================================================
  // Configuration register locations
  localparam logic [7:0] REG_ID = 8'h00;
  localparam logic [7:0] REG_START = 8'h01;
  localparam int START_BIT = 0;
  localparam logic [7:0] REG_SPI_RATE = 8'h0C;
  localparam int RATE_LSB = 4;
  localparam int RATE_MSB = 5;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  // ============================================================
  // Management frame layout
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] FULL_SEL = 2'h3;
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0B;
  localparam logic [5:0] BODY_LAST = 6'h11;
  localparam logic [4:0] RD_RELEASE = 5'h12;
  localparam logic [4:0] STD_REG_MAX = 5'h05;
  localparam logic [4:0] STD_REG_A = 5'h1D;
  localparam logic [4:0] STD_REG_B = 5'h1F;

  // ============================================================
  // Timing
  localparam int MCLK_KHZ = 25000;
  localparam int START_CLR_US = 100;
  localparam int START_CLR_CYC = (START_CLR_US * MCLK_KHZ) / 1000;
  localparam logic [11:0] START_CLR_CNT = 12'(START_CLR_CYC);
  localparam logic [4:0] SYNC_IDLE = 5'h12;

  // ============================================================
  // Types
  typedef enum logic [3:0] {
    SPI_CMD = 4'h1,
    SPI_ADDR = 4'h2,
    SPI_DATA = 4'h4,
    SPI_SKIP = 4'h8
  } sca_spi_st_t;

  typedef enum logic [3:0] {
    MD_PRE = 4'h1,
    MD_START = 4'h2,
    MD_HDR = 4'h4,
    MD_BODY = 4'h8
  } sca_mdio_st_t;

  typedef struct packed {
    logic we;
    logic [4:0] phy;
    logic [4:0] reg_addr_field;
    logic [15:0] wdata;
  } sca_phy_req_t;

  typedef struct packed {
    logic start_switch;
    logic [1:0] spi_rate;
  } sca_cfg_t;

endpackage

// File: rtl/sca_top.sv
`timescale 1ns/1ps
module sca_top #(
  parameter logic [7:0] FAMILY_ID = 8'h5A  // Arbitrary value
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [1:0] interface_select_strap,
  input wire logic serial_slave_select_n,
  input wire logic serial_config_clock,
  input wire logic serial_data_to_device,
  output logic serial_data_from_device,
  output logic serial_data_from_device_oe,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic phy_req_valid,
  output sca_pkg::sca_phy_req_t phy_req,
  input wire logic [15:0] phy_rdata,
  output sca_pkg::sca_cfg_t cfg,
  output logic cfg_ready
);

  // ============================================================
  // Pin synchronisers and edge detection
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [1:0] strap1;
  logic [1:0] strap2;

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1 <= sca_pkg::SYNC_IDLE;
      sync2 <= sca_pkg::SYNC_IDLE;
      sync3 <= sca_pkg::SYNC_IDLE;
      strap1 <= 2'h0;
      strap2 <= 2'h0;
    end else if (ce) begin
      sync1 <= {mdio_in, mdc, serial_data_to_device, serial_slave_select_n, serial_config_clock};
      sync2 <= sync1;
      sync3 <= sync2;
      strap1 <= interface_select_strap;
      strap2 <= strap1;
    end
  end

  wire sclk_rise = sync2[0] & ~sync3[0];
  wire sclk_fall = ~sync2[0] & sync3[0];
  wire ss_n_s = sync2[1];
  wire sdi_s = sync2[2];
  // Sampling limits the link clocks to well below mclk; fine for an MDC of mclk/8 (3.125 MHz)
  wire mdc_rise = sync2[3] & ~sync3[3];
  wire mdc_fall = ~sync2[3] & sync3[3];
  wire mdio_s = sync2[4];

  // ============================================================
  // Strap capture and start-bit hold-off
  logic strap_spi;
  logic strap_taken;
  logic [11:0] boot_cnt;

  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_spi <= 1'b0;
      strap_taken <= 1'b0;
      boot_cnt <= 12'h000;
      cfg_ready <= 1'b0;
    end else if (ce) begin
      // Strap passes the synchroniser before it is caught once
      if (!strap_taken && boot_cnt == 12'h002) begin
        strap_spi <= (strap2 == sca_pkg::STRAP_SPI);
        strap_taken <= 1'b1;
      end
      if (boot_cnt != sca_pkg::START_CLR_CNT) begin
        boot_cnt <= boot_cnt + 12'h001;
      end
      cfg_ready <= (boot_cnt == sca_pkg::START_CLR_CNT);
    end
  end

  // ============================================================
  // Register file
  logic [7:0] regs [0:255];
  logic spi_wr_en;
  logic [7:0] spi_wr_addr;
  logic [7:0] spi_wr_data;
  logic mdio_wr_en;
  logic [7:0] mdio_wr_addr;
  logic [7:0] mdio_wr_data;
  logic hold_v;
  logic [7:0] hold_addr;
  logic [7:0] hold_data;

  function automatic logic [7:0] reg_read(input logic [7:0] a);
    reg_read = (a == sca_pkg::REG_ID) ? FAMILY_ID : regs[a];
  endfunction

  // Start switching stays blocked until the hold-off has run out
  function automatic logic [7:0] wr_val(input logic [7:0] a, input logic [7:0] d,
                                        input logic rdy);
    wr_val = d;
    if (a == sca_pkg::REG_START && !rdy) begin
      wr_val[sca_pkg::START_BIT] = 1'b0;
    end
  endfunction

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) begin
        regs[i] <= sca_pkg::REG_RESET_VAL;
      end
      hold_v <= 1'b0;
      hold_addr <= 8'h00;
      hold_data <= 8'h00;
      cfg <= '0;
    end else if (ce) begin
      if (spi_wr_en && spi_wr_addr != sca_pkg::REG_ID) begin
        regs[spi_wr_addr] <= wr_val(spi_wr_addr, spi_wr_data, cfg_ready);
      end
      // A colliding management write waits one slot rather than being lost
      if (spi_wr_en && mdio_wr_en) begin
        hold_v <= 1'b1;
        hold_addr <= mdio_wr_addr;
        hold_data <= mdio_wr_data;
      end else if (!spi_wr_en && hold_v) begin
        hold_v <= 1'b0;
        if (hold_addr != sca_pkg::REG_ID) begin
          regs[hold_addr] <= wr_val(hold_addr, hold_data, cfg_ready);
        end
      end else if (!spi_wr_en && mdio_wr_en && mdio_wr_addr != sca_pkg::REG_ID) begin
        regs[mdio_wr_addr] <= wr_val(mdio_wr_addr, mdio_wr_data, cfg_ready);
      end
      cfg.start_switch <= regs[sca_pkg::REG_START][sca_pkg::START_BIT];
      cfg.spi_rate <= regs[sca_pkg::REG_SPI_RATE][sca_pkg::RATE_MSB:sca_pkg::RATE_LSB];
    end
  end

  // ============================================================
  // SPI slave, receive side
  sca_pkg::sca_spi_st_t spi_st;
  logic spi_rd;
  logic [2:0] spi_bit;
  logic [7:0] spi_sh;
  logic [7:0] spi_addr;
  logic [7:0] tx_byte;
  logic tx_load;
  logic [7:0] tx_sh;

  wire spi_sel = ~ss_n_s & strap_spi;
  wire [7:0] spi_byte = {spi_sh[6:0], sdi_s};
  wire [7:0] next_spi_addr = spi_addr + 8'h01;

  always_ff @(posedge mclk) begin
    if (rst) begin
      spi_st <= sca_pkg::SPI_CMD;
      spi_rd <= 1'b0;
      spi_bit <= 3'h0;
      spi_sh <= 8'h00;
      spi_addr <= 8'h00;
      tx_byte <= 8'h00;
      tx_load <= 1'b0;
      spi_wr_en <= 1'b0;
      spi_wr_addr <= 8'h00;
      spi_wr_data <= 8'h00;
    end else if (ce) begin
      spi_wr_en <= 1'b0;
      tx_load <= 1'b0;
      if (!spi_sel) begin
        spi_st <= sca_pkg::SPI_CMD;
        spi_bit <= 3'h0;
        spi_rd <= 1'b0;
      end else if (sclk_rise) begin
        spi_sh <= spi_byte;
        spi_bit <= spi_bit + 3'h1;
        if (spi_bit == 3'h7) begin
          case (spi_st)
            sca_pkg::SPI_CMD: begin
              spi_rd <= (spi_byte == sca_pkg::CMD_READ);
              if (spi_byte == sca_pkg::CMD_READ || spi_byte == sca_pkg::CMD_WRITE) begin
                spi_st <= sca_pkg::SPI_ADDR;
              end else begin
                spi_st <= sca_pkg::SPI_SKIP;
              end
            end
            sca_pkg::SPI_ADDR: begin
              spi_addr <= spi_byte;
              spi_st <= sca_pkg::SPI_DATA;
              tx_byte <= reg_read(spi_byte);
              tx_load <= spi_rd;
            end
            sca_pkg::SPI_DATA: begin
              spi_addr <= next_spi_addr;
              if (spi_rd) begin
                tx_byte <= reg_read(next_spi_addr);
                tx_load <= 1'b1;
              end else begin
                spi_wr_en <= 1'b1;
                spi_wr_addr <= spi_addr;
                spi_wr_data <= spi_byte;
              end
            end
            default: begin
              spi_st <= sca_pkg::SPI_SKIP;
            end
          endcase
        end
      end
    end
  end

  // ============================================================
  // SPI slave, transmit side
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_sh <= 8'h00;
      serial_data_from_device <= 1'b0;
      serial_data_from_device_oe <= 1'b0;
    end else if (ce) begin
      if (!spi_sel) begin
        serial_data_from_device_oe <= 1'b0;
      end
      // Load follows a rise; the next fall is always several mclk later
      if (tx_load) begin
        tx_sh <= tx_byte;
      end else if (sclk_fall && spi_sel && spi_rd && spi_st == sca_pkg::SPI_DATA) begin
        serial_data_from_device <= tx_sh[7];
        tx_sh <= {tx_sh[6:0], 1'b0};
        serial_data_from_device_oe <= 1'b1;
      end
    end
  end

  // ============================================================
  // Management frame receiver
  sca_pkg::sca_mdio_st_t md_st;
  logic [5:0] md_cnt;
  logic [11:0] md_hdr;
  logic [15:0] md_data;
  logic [1:0] md_op;
  logic [4:0] md_phy;
  logic [4:0] md_reg;
  logic rd_start;

  function automatic logic is_std_reg(input logic [4:0] r);
    is_std_reg = (r <= sca_pkg::STD_REG_MAX) || r == sca_pkg::STD_REG_A ||
                 r == sca_pkg::STD_REG_B;
  endfunction

  function automatic logic [7:0] smi_addr(input logic [4:0] p, input logic [4:0] r);
    smi_addr = {p[4:3], p[0], r};
  endfunction

  wire [11:0] next_hdr = {md_hdr[10:0], mdio_s};
  wire [15:0] next_data = {md_data[14:0], mdio_s};
  wire md_full = (md_phy[2:1] == sca_pkg::FULL_SEL);
  wire hdr_full = (next_hdr[7:6] == sca_pkg::FULL_SEL);

  always_ff @(posedge mclk) begin
    if (rst) begin
      md_st <= sca_pkg::MD_PRE;
      md_cnt <= 6'h00;
      md_hdr <= 12'h000;
      md_data <= 16'h0000;
      md_op <= 2'h0;
      md_phy <= 5'h00;
      md_reg <= 5'h00;
      rd_start <= 1'b0;
      phy_req_valid <= 1'b0;
      phy_req <= '0;
      mdio_wr_en <= 1'b0;
      mdio_wr_addr <= 8'h00;
      mdio_wr_data <= 8'h00;
    end else if (ce) begin
      rd_start <= 1'b0;
      phy_req_valid <= 1'b0;
      mdio_wr_en <= 1'b0;
      if (mdc_rise) begin
        case (md_st)
          sca_pkg::MD_PRE: begin
            if (mdio_s) begin
              if (md_cnt != sca_pkg::PREAMBLE_LEN) begin
                md_cnt <= md_cnt + 6'h01;
              end
            end else begin
              if (md_cnt == sca_pkg::PREAMBLE_LEN) begin
                md_st <= sca_pkg::MD_START;
              end
              md_cnt <= 6'h00;
            end
          end
          sca_pkg::MD_START: begin
            md_st <= mdio_s ? sca_pkg::MD_HDR : sca_pkg::MD_PRE;
            md_cnt <= 6'h00;
          end
          sca_pkg::MD_HDR: begin
            md_hdr <= next_hdr;
            md_cnt <= md_cnt + 6'h01;
            if (md_cnt == sca_pkg::HDR_LAST) begin
              md_cnt <= 6'h00;
              md_st <= sca_pkg::MD_BODY;
              md_op <= next_hdr[11:10];
              md_phy <= next_hdr[9:5];
              md_reg <= next_hdr[4:0];
              if (next_hdr[11:10] == sca_pkg::OP_READ) begin
                rd_start <= 1'b1;
                if (!hdr_full && is_std_reg(next_hdr[4:0])) begin
                  phy_req_valid <= 1'b1;
                  phy_req <= {1'b0, next_hdr[9:5], next_hdr[4:0], 16'h0000};
                end
              end
            end
          end
          sca_pkg::MD_BODY: begin
            md_data <= next_data;
            md_cnt <= md_cnt + 6'h01;
            if (md_cnt == sca_pkg::BODY_LAST) begin
              md_cnt <= 6'h00;
              md_st <= sca_pkg::MD_PRE;
              if (md_op == sca_pkg::OP_WRITE) begin
                if (md_full) begin
                  mdio_wr_en <= 1'b1;
                  mdio_wr_addr <= smi_addr(md_phy, md_reg);
                  mdio_wr_data <= next_data[7:0];
                end else if (is_std_reg(md_reg)) begin
                  phy_req_valid <= 1'b1;
                  phy_req <= {1'b1, md_phy, md_reg, next_data};
                end
              end
            end
          end
          default: begin
            md_st <= sca_pkg::MD_PRE;
          end
        endcase
      end
    end
  end

  // ============================================================
  // Management read driver: fall 1 released, fall 2 drives zero
  logic rd_load;
  logic md_act;
  logic [4:0] md_fcnt;
  logic [16:0] md_tx;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_load <= 1'b0;
      md_act <= 1'b0;
      md_fcnt <= 5'h00;
      md_tx <= 17'h00000;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (ce) begin
      rd_load <= rd_start;
      if (rd_load) begin
        // PHY data is taken one cycle after the request pulse
        md_tx <= md_full ? {9'h000, reg_read(smi_addr(md_phy, md_reg))} :
                 {1'b0, is_std_reg(md_reg) ? phy_rdata : 16'h0000};
        md_fcnt <= 5'h00;
        md_act <= 1'b1;
      end else if (mdc_fall && md_act) begin
        md_fcnt <= md_fcnt + 5'h01;
        if (md_fcnt == sca_pkg::RD_RELEASE) begin
          mdio_oe <= 1'b0;
          md_act <= 1'b0;
        end else if (md_fcnt != 5'h00) begin
          mdio_oe <= 1'b1;
          mdio_out <= md_tx[16];
          md_tx <= {md_tx[15:0], 1'b0};
        end
      end
    end
  end

  // ============================================================
  // Checks
  sequence s_cmd_byte;
    ce && spi_sel && sclk_rise && spi_bit == 3'h7 && spi_st == sca_pkg::SPI_CMD;
  endsequence

  sequence s_data_byte;
    ce && spi_sel && sclk_rise && spi_bit == 3'h7 && spi_st == sca_pkg::SPI_DATA;
  endsequence

  property p_cmd_read;
    @(posedge mclk) disable iff (rst)
      s_cmd_byte and (spi_byte == sca_pkg::CMD_READ) |=> spi_st == sca_pkg::SPI_ADDR && spi_rd;
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("read command not decoded");

  property p_addr_inc;
    @(posedge mclk) disable iff (rst)
      s_data_byte |=> spi_addr == $past(spi_addr) + 8'h01;
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("address did not advance");

  property p_addr_wrap;
    @(posedge mclk) disable iff (rst)
      s_data_byte and (spi_addr == 8'hFF) |=> spi_addr == 8'h00;
  endproperty
  a_addr_wrap: assert property (p_addr_wrap) else $error("address did not wrap");

  property p_sel_end;
    @(posedge mclk) disable iff (rst)
      ce && !spi_sel |=> spi_st == sca_pkg::SPI_CMD && spi_bit == 3'h0
                         ##1 !serial_data_from_device_oe;
  endproperty
  a_sel_end: assert property (p_sel_end) else $error("deselect did not end transfer");

  property p_start_clear;
    @(posedge mclk) disable iff (rst)
      !cfg_ready |-> !cfg.start_switch;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit set too early");

  property p_sdo_fall;
    @(posedge mclk) disable iff (rst)
      $changed(serial_data_from_device) |-> $past(sclk_fall) && $past(spi_rd);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("output changed off a fall");

  property p_strap_gate;
    @(posedge mclk) disable iff (rst)
      !strap_spi |-> spi_st == sca_pkg::SPI_CMD && !serial_data_from_device_oe;
  endproperty
  a_strap_gate: assert property (p_strap_gate) else $error("port active without strap");

  property p_ta_zero;
    @(posedge mclk) disable iff (rst)
      $rose(mdio_oe) |-> !mdio_out && md_fcnt == 5'h02;
  endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("turnaround not driven as zero");

  property p_full_high_zero;
    @(posedge mclk) disable iff (rst)
      ce && rd_load && md_full |=> md_tx[16:8] == 9'h000;
  endproperty
  a_full_high_zero: assert property (p_full_high_zero) else $error("high byte not zero");

  property p_full_write;
    @(posedge mclk) disable iff (rst)
      mdio_wr_en |-> md_op == sca_pkg::OP_WRITE && md_phy[2:1] == 2'h3 &&
                     mdio_wr_addr == {md_phy[4], md_phy[3], md_phy[0], md_reg};
  endproperty
  a_full_write: assert property (p_full_write) else $error("bad full-register write");

  property p_std_only;
    @(posedge mclk) disable iff (rst)
      phy_req_valid |-> phy_req.phy[2:1] != 2'h3 &&
                        (phy_req.reg_addr_field < 5'h06 || phy_req.reg_addr_field == 5'h1D ||
                         phy_req.reg_addr_field == 5'h1F);
  endproperty
  a_std_only: assert property (p_std_only) else $error("standard frame left PHY set");

endmodule

// File: sim/sca_master_model.sv
`timescale 1ns/1ps
module sca_master_model (
  input wire logic mclk,
  output logic ss_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic mdc,
  output logic mdio_wire,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic rd_stb,
  output logic [16:0] rd_val,
  output logic oe_seen
);
  logic m_oe;
  logic m_out;

  // ==========
  // Line levels
  initial begin
    ss_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    mdc = 1'b0;
    m_oe = 1'b0;
    m_out = 1'b0;
    rd_stb = 1'b0;
    rd_val = '0;
    oe_seen = 1'b0;
  end
  // Pull-up holds the management line when nobody drives it
  assign mdio_wire = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);
  // A deselected data line must not look like a held value
  always @(negedge mclk) if (ss_n) sdi <= ~sdi;
  always @(posedge mclk) if (sdo_oe) oe_seen <= 1'b1;

  // ==========
  // Serial port master
  task automatic half();
    repeat (4) @(negedge mclk);
  endtask

  task automatic stb();
    rd_stb = 1'b1;
    @(negedge mclk);
    rd_stb = 1'b0;
  endtask

  task automatic spi_bits(input logic [7:0] b, input int nb, output logic [7:0] r);
    for (int i = 7; i > 7 - nb; i--) begin
      sclk = 1'b0;
      sdi = b[i];
      half();
      // An undriven output line shows the inverse so a missing bit cannot pass
      r[i] = sdo_oe ? sdo : ~sdo;
      sclk = 1'b1;
      half();
    end
  endtask

  task automatic spi(input logic [7:0] cmd, input logic [7:0] addr, input int n,
                     input logic [31:0] wd, input int tail);
    logic [7:0] r;
    ss_n = 1'b0;
    half();
    spi_bits(cmd, 8, r);
    spi_bits(addr, 8, r);
    // Bytes follow each other with no pause beyond the one-cycle read strobe, to keep the counter fed
    for (int k = 0; k < n; k++) begin
      spi_bits(wd[31 - 8 * k -: 8], 8, r);
      rd_val = {9'h000, r};
      if (cmd == sca_pkg::CMD_READ) stb();
    end
    if (tail > 0) spi_bits(8'hFF, tail, r);
    sclk = 1'b0;
    half();
    ss_n = 1'b1;
    half();
    half();
  endtask

  // ==========
  // Management frame master
  task automatic mdio(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd);
    logic [63:0] f;
    logic rdop;
    rdop = (op == sca_pkg::OP_READ);
    f = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      mdc = 1'b0;
      m_oe = !(rdop && i < 18);
      m_out = f[i];
      half();
      if (i < 17) rd_val[i] = mdio_wire;
      mdc = 1'b1;
      half();
    end
    mdc = 1'b0;
    m_oe = 1'b0;
    half();
    half();
    if (rdop) stb();
  endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] FAM = 8'h3C; // Arbitrary value
  logic mclk, rst, ce, ss_n, sclk, sdi, sdo, sdo_oe, mdc, mdio_wire, mdio_out, mdio_oe;
  logic req_v, rdy, rd_stb, oe_seen;
  logic [1:0] strap;
  logic [15:0] phy_rdata;
  logic [16:0] rd_val;
  sca_pkg::sca_phy_req_t req;
  sca_pkg::sca_cfg_t cfg;
  logic [16:0] exp_rd[$];
  sca_pkg::sca_phy_req_t exp_req[$];
  logic [31:0] seed;
  logic [7:0] a, b0, b1;
  logic [4:0] regs [6] = '{5'h00, 5'h05, 5'h1D, 5'h1F, 5'h06, 5'h1E};
  int fail_count, tests_run;
  time t0;

  sca_top #(.FAMILY_ID(FAM)) dut (
    .mclk(mclk), .rst(rst), .ce(ce), .interface_select_strap(strap),
    .serial_slave_select_n(ss_n), .serial_config_clock(sclk), .serial_data_to_device(sdi),
    .serial_data_from_device(sdo), .serial_data_from_device_oe(sdo_oe), .mdc(mdc),
    .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_req_valid(req_v),
    .phy_req(req), .phy_rdata(phy_rdata), .cfg(cfg), .cfg_ready(rdy));

  sca_master_model m (
    .mclk(mclk), .ss_n(ss_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .mdc(mdc), .mdio_wire(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .rd_stb(rd_stb), .rd_val(rd_val), .oe_seen(oe_seen));

  // ==========
  // Checking
  task automatic miss(input string what);
    fail_count++;
    $display("wrong value at %0t: %s", $time, what);
  endtask

  task automatic cmp_rd(input logic [16:0] got, input logic [16:0] exp);
    tests_run++;
    if (got !== exp) miss($sformatf("read %h expected %h", got, exp));
  endtask

  task automatic cmp_req(input sca_pkg::sca_phy_req_t got, input sca_pkg::sca_phy_req_t exp);
    tests_run++;
    if (got[26:16] !== exp[26:16] || (exp.we && got.wdata !== exp.wdata))
      miss($sformatf("phy request %h expected %h", got, exp));
  endtask

  task automatic cmp_flag(input logic [5:0] got, input logic [5:0] exp, input string what);
    tests_run++;
    if (got !== exp) miss($sformatf("%s %h expected %h", what, got, exp));
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  always @(posedge rd_stb) begin
    if (exp_rd.size() == 0) miss("unexpected read");
    else cmp_rd(rd_val, exp_rd.pop_front());
  end

  // Sampled away from the launching edge so the pulse is seen settled
  always @(negedge mclk) begin
    if (req_v === 1'b1) begin
      if (exp_req.size() == 0) miss("unexpected phy request");
      else cmp_req(req, exp_req.pop_front());
    end
  end

  // ==========
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    #3000000;
    miss("timeout");
    end_sim();
  end

  // ==========
  // Scenarios
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    strap = sca_pkg::STRAP_SPI;
    phy_rdata = 16'h0000;
    seed = 32'h0000BD75;
    fail_count = 0;
    tests_run = 0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    t0 = $time;
    repeat (8) @(negedge mclk);
    cmp_flag({cfg, rdy, sdo_oe, mdio_oe}, 6'h00, "reset outputs");
    m.spi(sca_pkg::CMD_WRITE, sca_pkg::REG_START, 1, 32'h01000000, 0);
    repeat (4) @(negedge mclk);
    cmp_flag({3'h0, cfg.start_switch, rdy, 1'b0}, 6'h00, "start before ready");
    // Clock enable low freezes the hold-off, so ready comes that much later
    ce = 1'b0;
    repeat (100) @(negedge mclk);
    ce = 1'b1;
    for (int i = 0; i < 3000 && rdy !== 1'b1; i++) @(negedge mclk);
    cmp_flag({5'h00, ($time - t0) / 40 inside {[2595:2605]}}, 6'h01, "ready time");
    $display("test start hold-off done");

    m.spi(sca_pkg::CMD_WRITE, sca_pkg::REG_SPI_RATE, 1, 32'h20000000, 0);
    m.spi(sca_pkg::CMD_WRITE, sca_pkg::REG_START, 1, 32'h01000000, 0);
    repeat (4) @(negedge mclk);
    cmp_flag({3'h0, cfg}, 6'h06, "config outputs");
    $display("test start and rate done");

    seed = xs(seed);
    {b0, b1} = seed[15:0];
    m.spi(sca_pkg::CMD_WRITE, 8'hFE, 3, {b0, b1, 16'h7700}, 0);
    m.spi(8'h05, 8'hFE, 1, 32'h11000000, 0);
    m.spi(sca_pkg::CMD_WRITE, 8'hFF, 0, 32'h0, 5);
    exp_rd.push_back({9'h000, b0});
    exp_rd.push_back({9'h000, b1});
    exp_rd.push_back({9'h000, FAM});
    m.spi(sca_pkg::CMD_READ, 8'hFE, 3, 32'h0, 0);
    cmp_flag({5'h00, oe_seen}, 6'h01, "read drive");
    $display("test wrap and refusals done");

    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      a = {2'h1, seed[5:0]};
      m.mdio(sca_pkg::OP_WRITE, {a[7:6], 2'h3, a[5]}, a[4:0], seed[31:16]);
      exp_rd.push_back({9'h000, seed[23:16]});
      m.spi(sca_pkg::CMD_READ, a, 1, 32'h0, 0);
      m.spi(sca_pkg::CMD_WRITE, a, 1, {seed[15:8], 24'h0}, 0);
      exp_rd.push_back({9'h000, seed[15:8]});
      m.mdio(sca_pkg::OP_READ, {a[7:6], 2'h3, a[5]}, a[4:0], 16'hFFFF);
    end
    $display("test full register mode done");

    foreach (regs[k]) begin
      phy_rdata = {8'hC3, 3'h0, regs[k]};
      if (k < 4) begin
        exp_req.push_back({1'b0, 5'h01, regs[k], 16'h0000});
        exp_rd.push_back({1'b0, phy_rdata});
      end
      else exp_rd.push_back(17'h00000);
      m.mdio(sca_pkg::OP_READ, 5'h01, regs[k], 16'hFFFF);
    end
    exp_req.push_back({1'b1, 5'h02, 5'h1D, 16'hBEEF});
    m.mdio(sca_pkg::OP_WRITE, 5'h02, 5'h1D, 16'hBEEF);
    m.mdio(sca_pkg::OP_WRITE, 5'h02, 5'h06, 16'h1234);
    repeat (8) @(negedge mclk);
    $display("test standard frames done");

    rst = 1'b1;
    strap = 2'h0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    m.oe_seen = 1'b0;
    repeat (8) @(negedge mclk);
    cmp_flag({cfg, rdy, sdo_oe, mdio_oe}, 6'h00, "second reset outputs");
    m.spi(sca_pkg::CMD_READ, 8'h00, 0, 32'h0, 2);
    cmp_flag({5'h00, oe_seen}, 6'h00, "strap off drive");
    cmp_flag({exp_rd.size() == 0, exp_req.size() == 0, 4'h0}, 6'h30, "pending notes");
    $display("test strap select done");
    end_sim();
  end
endmodule
